// ==== urf_consts.svh ====
// Purpose: Offsets, field positions and reset values of the receive flag block.
// Assumes: Included by the package and by the design module.
// Notes:   Byte addresses on APB, one aligned 32-bit word per register.
`ifndef URF_CONSTS_SVH
`define URF_CONSTS_SVH

`define URF_ADDR_W      12
`define URF_OFF_DATA    12'h000
`define URF_OFF_STATUS  12'h004
`define URF_OFF_MASK    12'h008
`define URF_OFF_CTRL    12'h00c
`define URF_OFF_ABAUD   12'h010

`define URF_FLAGS_W     6
`define URF_BIT_OVER    0
`define URF_BIT_ABDONE  1
`define URF_BIT_ABTO    2
`define URF_BIT_ADDR    3
`define URF_BIT_PAR     4
`define URF_BIT_FRM     5

`define URF_CTRL_PAR_EN 0
`define URF_CTRL_PAR_OD 1
`define URF_CTRL_RS485  2
`define URF_CTRL_ABR_GO 3
`define URF_CTRL_ADR_EN 15
`define URF_CTRL_DIV_LO 16
`define URF_CTRL_DIV_HI 31

`define URF_DIV_RESET   16'h0010
`define URF_MASK_RESET  6'h00
`define URF_DATA_BITS   8
`define URF_NINTH_IDX   8

`endif

// ==== urf_pkg.sv ====
// Purpose: Types shared by the receive flag block.
// Assumes: urf_consts.svh on the include path.
// Notes:   Constants live in the header, types here.
`default_nettype none
`include "urf_consts.svh"

package urf_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BITS,
    ST_STOP
  } urf_state_type;

  typedef struct packed {
    logic                      ninth;
    logic [`URF_DATA_BITS-1:0] data;
  } urf_char_type;

  typedef struct packed {
    logic        addr_en;
    logic        rs485;
    logic        par_odd;
    logic        par_en;
    logic [15:0] div;
  } urf_ctrl_type;

endpackage : urf_pkg

`default_nettype wire

// ==== urf_rx_flags.sv ====
// Purpose: UART receiver with sticky error and event flags, FIFO and autobaud, on APB.
// Assumes: rx_pin is asynchronous; APB master per the usual two-phase protocol.
// Notes:   Zero wait states; unmapped addresses answer with pslverr.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`default_nettype none
`include "urf_consts.svh"

// Operation
// R1 - Stop bit sampled low after last data or parity bit sets framing flag.
// R2 - Parity bit disagreeing with configured parity sets parity flag.
// R3 - In RS-485 mode a word with ninth bit one sets address flag.
// R4 - Address flag only set with RS-485 mode and address detect enable.
// R5 - Autobaud counter overflow while measuring sets autobaud timeout flag.
// R6 - Autobaud measurement finishing sets autobaud done flag.
// R7 - Byte arriving while 16-deep FIFO is full sets overflow flag.
// R8 - Byte arriving while single-byte buffer is occupied sets overflow flag.
// R9 - Flags are read-only, sticky, cleared exactly where software writes one.
// R10 - Written zeros leave flags alone; a set event beats a same-cycle clear.
module urf_rx_flags
  import urf_pkg::*;
#(
  parameter int RX_DEPTH  = 16,
  parameter int ABR_CNT_W = 16
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`URF_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   rx_pin,
  output logic                        irq
);

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  logic                     rx_meta_q;
  logic                     rx_s_q;
  urf_ctrl_type             ctrl_q;
  logic [`URF_FLAGS_W-1:0]  flags_q;
  logic [`URF_FLAGS_W-1:0]  mask_q;
  logic [`URF_FLAGS_W-1:0]  ev;
  logic [`URF_FLAGS_W-1:0]  clr;
  urf_state_type            state_q;
  logic [15:0]              tick_q;
  logic [3:0]               idx_q;
  logic [3:0]               last_idx;
  logic [`URF_NINTH_IDX:0]  shift_q;
  logic                     done;
  logic                     par_bad;
  urf_char_type             mem_q [RX_DEPTH];
  logic [PTR_W-1:0]         wptr_q;
  logic [PTR_W-1:0]         rptr_q;
  logic [CNT_W-1:0]         count_q;
  logic                     full;
  logic                     empty;
  logic                     push;
  logic                     pop;
  logic                     abr_run_q;
  logic                     abr_meas_q;
  logic [ABR_CNT_W-1:0]     abr_cnt_q;
  logic [ABR_CNT_W-1:0]     abr_res_q;
  logic                     abr_done;
  logic                     abr_tout;
  logic                     setup;
  logic                     wr_acc;
  logic                     rd_acc;
  logic                     hit;
  logic [31:0]              rd_mux;

  // APB decode; reads are latched in the setup cycle so prdata comes from flops
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & ~pslverr;
  assign rd_acc = psel & penable & ~pwrite & ~pslverr;
  assign pready = 1'b1;
  assign hit    = (paddr == `URF_OFF_DATA) | (paddr == `URF_OFF_STATUS) |
                  (paddr == `URF_OFF_MASK) | (paddr == `URF_OFF_CTRL) |
                  (paddr == `URF_OFF_ABAUD);

  always_comb begin
    rd_mux = '0;
    case (paddr)
      `URF_OFF_DATA:   rd_mux = {23'h000000, mem_q[rptr_q]};
      `URF_OFF_STATUS: rd_mux = {26'h0000000, flags_q};
      `URF_OFF_MASK:   rd_mux = {26'h0000000, mask_q};
      `URF_OFF_CTRL: begin
        rd_mux[`URF_CTRL_DIV_HI:`URF_CTRL_DIV_LO] = ctrl_q.div;
        rd_mux[`URF_CTRL_ADR_EN] = ctrl_q.addr_en;
        rd_mux[`URF_CTRL_ABR_GO] = abr_run_q;
        rd_mux[`URF_CTRL_RS485]  = ctrl_q.rs485;
        rd_mux[`URF_CTRL_PAR_OD] = ctrl_q.par_odd;
        rd_mux[`URF_CTRL_PAR_EN] = ctrl_q.par_en;
      end
      `URF_OFF_ABAUD:  rd_mux = 32'(abr_res_q);
      default:         rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? '0 : (empty && paddr == `URF_OFF_DATA ? '0 : rd_mux);
      pslverr <= ~hit;
    end
  end

  // Control and mask registers
  // Autobaud go is not stored here; it only starts a run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= '0;
      ctrl_q.div <= `URF_DIV_RESET;
      mask_q     <= `URF_MASK_RESET;
    end else if (wr_acc) begin
      if (paddr == `URF_OFF_CTRL) begin
        ctrl_q.div     <= pwdata[`URF_CTRL_DIV_HI:`URF_CTRL_DIV_LO];
        ctrl_q.addr_en <= pwdata[`URF_CTRL_ADR_EN];
        ctrl_q.rs485   <= pwdata[`URF_CTRL_RS485];
        ctrl_q.par_odd <= pwdata[`URF_CTRL_PAR_OD];
        ctrl_q.par_en  <= pwdata[`URF_CTRL_PAR_EN];
      end
      if (paddr == `URF_OFF_MASK) begin
        mask_q <= pwdata[`URF_FLAGS_W-1:0];
      end
    end
  end

  // Two-flop synchroniser on the serial input
  // Reset to the idle level so no false start follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_s_q    <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_s_q    <= rx_meta_q;
    end
  end

  // One extra bit after the data: ninth bit in RS-485 mode, else parity if enabled
  assign last_idx = (ctrl_q.rs485 | ctrl_q.par_en) ? 4'(`URF_NINTH_IDX) :
                                                     4'(`URF_NINTH_IDX - 1);
  assign done     = (state_q == ST_STOP) && (tick_q == '0);
  assign par_bad  = ((^shift_q[`URF_DATA_BITS-1:0]) ^ shift_q[`URF_NINTH_IDX]) !=
                    ctrl_q.par_odd;

  // Receiver is held idle while autobaud measures, so one edge is not seen twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      tick_q  <= '0;
      idx_q   <= '0;
      shift_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!abr_run_q && !rx_s_q) begin
            state_q <= ST_START;
            tick_q  <= ctrl_q.div >> 1;
          end
        end
        ST_START: begin
          if (tick_q != '0) begin
            tick_q <= tick_q - 16'h0001;
          end else if (!rx_s_q) begin
            state_q <= ST_BITS;
            tick_q  <= ctrl_q.div - 16'h0001;
            idx_q   <= '0;
            shift_q <= '0;
          end else begin
            // Line back high at mid start: a glitch, not a frame
            state_q <= ST_IDLE;
          end
        end
        ST_BITS: begin
          if (tick_q != '0) begin
            tick_q <= tick_q - 16'h0001;
          end else begin
            shift_q[idx_q] <= rx_s_q;
            tick_q         <= ctrl_q.div - 16'h0001;
            idx_q          <= idx_q + 4'h1;
            if (idx_q == last_idx) begin
              state_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick_q != '0) begin
            tick_q <= tick_q - 16'h0001;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Receive FIFO; the incoming byte is dropped on overflow, the stored ones kept
  // A pop in the same cycle frees a slot, so a full FIFO still takes the byte
  assign full  = (count_q == CNT_FULL);
  assign empty = (count_q == '0);
  assign pop   = rd_acc && (paddr == `URF_OFF_DATA) && !empty;
  assign push  = done && (!full || pop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == PTR_LAST) ? '0 : wptr_q + PTR_W'(1);
      end
      if (pop) begin
        rptr_q <= (rptr_q == PTR_LAST) ? '0 : rptr_q + PTR_W'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + CNT_W'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CNT_W'(1);
      end
    end
  end

  // Storage needs no reset; only entries behind the write pointer are read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wptr_q] <= {shift_q[`URF_NINTH_IDX] & ctrl_q.rs485,
                        shift_q[`URF_DATA_BITS-1:0]};
    end
  end

  // Autobaud: measure the low time of the first start bit in pclk cycles
  // Timeout fires at all ones, one count before the counter would wrap
  assign abr_done = abr_meas_q && rx_s_q;
  assign abr_tout = abr_meas_q && !rx_s_q && (&abr_cnt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abr_run_q  <= 1'b0;
      abr_meas_q <= 1'b0;
      abr_cnt_q  <= '0;
      abr_res_q  <= '0;
    end else begin
      if (abr_done) begin
        abr_res_q  <= abr_cnt_q;
        abr_run_q  <= 1'b0;
        abr_meas_q <= 1'b0;
      end else if (abr_tout) begin
        abr_run_q  <= 1'b0;
        abr_meas_q <= 1'b0;
      end else if (abr_meas_q) begin
        abr_cnt_q <= abr_cnt_q + ABR_CNT_W'(1);
      end else if (abr_run_q && !rx_s_q && state_q == ST_IDLE) begin
        abr_meas_q <= 1'b1;
        abr_cnt_q  <= ABR_CNT_W'(1);
      end else if (wr_acc && paddr == `URF_OFF_CTRL && pwdata[`URF_CTRL_ABR_GO]) begin
        abr_run_q <= 1'b1;
      end
    end
  end

  // Flag events
  // Parity is not checked in RS-485 mode; the extra bit is the address mark
  always_comb begin
    ev                  = '0;
    ev[`URF_BIT_FRM]    = done && !rx_s_q;                                   // see R1
    ev[`URF_BIT_PAR]    = done && ctrl_q.par_en && !ctrl_q.rs485 && par_bad; // see R2
    ev[`URF_BIT_ADDR]   = done && ctrl_q.rs485 && ctrl_q.addr_en &&          // see R4
                          shift_q[`URF_NINTH_IDX];                           // see R3
    ev[`URF_BIT_ABTO]   = abr_tout;                                          // see R5
    ev[`URF_BIT_ABDONE] = abr_done;                                          // see R6
    ev[`URF_BIT_OVER]   = done && full && !pop;                         // see R7 see R8
  end

  assign clr = (wr_acc && paddr == `URF_OFF_STATUS) ? pwdata[`URF_FLAGS_W-1:0] : '0;

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clr) | ev; // see R9 see R10
    end
  end

  // Level output; drops as soon as software clears or masks the flag
  assign irq = |(flags_q & mask_q);

endmodule : urf_rx_flags

`default_nettype wire

// ==== urf_uart_tx_model.sv ====
// Purpose: Remote serial transmitter that drives the receive line.
// Assumes: Tasks are called right after a rising edge of pclk.
// Notes:   Line idles high between frames, like a real transmitter.
`default_nettype none
module urf_uart_tx_model #(
  parameter int DIV = 8
) (
  input  wire logic pclk,
  output var  logic rx_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_pin = 1'b1;
  task automatic bit_out(input logic v, input int n);
    rx_pin <= v;
    repeat (n) @(posedge pclk);
  endtask : bit_out
  task automatic send(input logic [8:0] w, input logic extra, input logic stop_v);
    bit_out(1'b0, DIV);
    for (int i = 0; i < 8; i++) bit_out(w[i], DIV);
    if (extra) bit_out(w[8], DIV);
    bit_out(stop_v, DIV);
    bit_out(1'b1, 2 * DIV);
  endtask : send
  // Low pulse for rate measurement; no stop framing around it
  task automatic low(input int n);
    bit_out(1'b0, n);
    bit_out(1'b1, 2 * DIV);
  endtask : low
endmodule : urf_uart_tx_model
`default_nettype wire

// ==== urf_rx_flags_chk.sv ====
// Purpose: Port-level checks of the receive flag block.
// Assumes: Bound into urf_rx_flags.
// Notes:   Flags are seen only through reads and irq.
`default_nettype none
`include "urf_consts.svh"
module urf_rx_flags_chk #(
  parameter int ABR_CNT_W = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_pin,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic setup  = psel && !penable;
  wire logic mapped = paddr inside {`URF_OFF_DATA, `URF_OFF_STATUS, `URF_OFF_MASK,
                                    `URF_OFF_CTRL, `URF_OFF_ABAUD};
  status_rsvd_a: assert property (rd_acc && paddr == `URF_OFF_STATUS |-> prdata[31:6] == 26'h0)
    else $error("status reserved bits set");
  // A flag only goes away by a clear or mask write, never on its own
  irq_sticky_a: assert property ($fell(irq) |-> $past(wr_acc &&
    (paddr == `URF_OFF_STATUS || paddr == `URF_OFF_MASK))) else $error("irq dropped alone");
  irq_mask_a: assert property (wr_acc && paddr == `URF_OFF_MASK && pwdata[5:0] == 6'h00
    |=> !irq) else $error("irq high with zero mask");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr) else $error("mapped refused");
  data_rsvd_a: assert property (rd_acc && paddr == `URF_OFF_DATA |-> prdata[31:9] == 23'h0)
    else $error("data word too wide");
  abaud_width_a: assert property (rd_acc && paddr == `URF_OFF_ABAUD |->
    (prdata >> ABR_CNT_W) == 32'h0) else $error("rate count too wide");
  // Read data only moves at a setup edge, so it stands through every access
  read_stable_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved in access");
  ready_high_a: assert property (psel && penable |-> pready) else $error("pready low");
endmodule : urf_rx_flags_chk
bind urf_rx_flags urf_rx_flags_chk #(.ABR_CNT_W(ABR_CNT_W)) urf_rx_flags_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_pin(rx_pin), .irq(irq));
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench of the receive flag block over APB.
// Assumes: Divisor 8 cycles per bit; short rate counter for timeouts.
// Notes:   A single-byte buffer variant shares the serial line and the APB signals.
`default_nettype none
`include "urf_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 8;
  localparam int DEPTH = 16;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, cb;
  logic        pready, pslverr, rx_pin, irq, err;
  logic        sel_one = 1'b0;
  logic [31:0] prdata_one;
  logic        pready_one, pslverr_one, irq_one;
  int          n_mismatch = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  urf_rx_flags #(.RX_DEPTH(DEPTH), .ABR_CNT_W(6)) urf_rx_flags_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel && !sel_one), .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .irq(irq));
  // The same serial line feeds a single-byte buffer variant
  urf_rx_flags #(.RX_DEPTH(1), .ABR_CNT_W(6)) urf_rx_flags_one_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel && sel_one), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_one),
    .pready(pready_one), .pslverr(pslverr_one), .rx_pin(rx_pin), .irq(irq_one));
  urf_uart_tx_model #(.DIV(DIV)) urf_uart_tx_model_inst (.pclk(pclk), .rx_pin(rx_pin));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while ((sel_one ? pready_one : pready) !== 1'b1);
    q = sel_one ? prdata_one : prdata;
    err = sel_one ? pslverr_one : pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in the same time step
    @(posedge pclk);
  endtask : apb
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask : rdc
  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cb = DIV << 16;
    rdc(`URF_OFF_STATUS, 32'h0, "status reset");
    rdc(`URF_OFF_CTRL, 32'h0010_0000, "ctrl reset");
    apb(1'b1, `URF_OFF_CTRL, cb);
    apb(1'b1, `URF_OFF_MASK, 32'h20);
    sel_one <= 1'b1;
    apb(1'b1, `URF_OFF_CTRL, cb);
    sel_one <= 1'b0;
    urf_uart_tx_model_inst.send(9'h055, 1'b0, 1'b0);
    rdc(`URF_OFF_STATUS, 32'h20, "framing");
    chk("irq set", {31'h0, irq}, 32'h1);
    apb(1'b1, `URF_OFF_STATUS, 32'h1f);
    rdc(`URF_OFF_STATUS, 32'h20, "zero write keeps");
    apb(1'b1, `URF_OFF_STATUS, 32'h20);
    rdc(`URF_OFF_STATUS, 32'h0, "one write clears");
    chk("irq clear", {31'h0, irq}, 32'h0);
    rdc(`URF_OFF_DATA, 32'h55, "framed byte");
    // Both parity senses, each with a good and a bad parity bit
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `URF_OFF_CTRL, cb | 32'h1 | (i[1] << 1));
      urf_uart_tx_model_inst.send({i[0], 8'h03}, 1'b1, 1'b1);
      rdc(`URF_OFF_STATUS, (i[0] != i[1]) ? 32'h10 : 32'h0, "parity");
      apb(1'b1, `URF_OFF_STATUS, 32'h3f);
      rdc(`URF_OFF_DATA, 32'h03, "parity byte");
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `URF_OFF_CTRL, cb | 32'h4 | (i[1] << 15));
      urf_uart_tx_model_inst.send({i[0], 8'ha6}, 1'b1, 1'b1);
      rdc(`URF_OFF_STATUS, (i[0] && i[1]) ? 32'h08 : 32'h0, "address");
      apb(1'b1, `URF_OFF_STATUS, 32'h3f);
      rdc(`URF_OFF_DATA, {23'h0, i[0], 8'ha6}, "address word");
    end
    apb(1'b1, `URF_OFF_CTRL, cb);
    for (int i = 0; i <= DEPTH; i++) urf_uart_tx_model_inst.send(i, 1'b0, 1'b1);
    rdc(`URF_OFF_STATUS, 32'h01, "overflow");
    for (int i = 0; i < DEPTH; i++) rdc(`URF_OFF_DATA, i, "fifo order");
    rdc(`URF_OFF_DATA, 32'h0, "fifo empty");
    apb(1'b1, `URF_OFF_STATUS, 32'h01);
    // One-byte buffer kept its first byte; every later one overflowed
    sel_one <= 1'b1;
    rdc(`URF_OFF_STATUS, 32'h21, "buffer overflow");
    rdc(`URF_OFF_DATA, 32'h55, "buffer kept");
    chk("buffer irq", {31'h0, irq_one}, 32'h0);
    sel_one <= 1'b0;
    apb(1'b1, `URF_OFF_CTRL, cb | 32'h8);
    urf_uart_tx_model_inst.low(20);
    rdc(`URF_OFF_STATUS, 32'h02, "rate done");
    rdc(`URF_OFF_CTRL, cb, "run cleared");
    rdc(`URF_OFF_ABAUD, 32'h14, "rate count");
    apb(1'b1, `URF_OFF_STATUS, 32'h02);
    apb(1'b1, `URF_OFF_CTRL, cb | 32'h8);
    urf_uart_tx_model_inst.low(100);
    rdc(`URF_OFF_STATUS, 32'h04, "rate timeout");
    rdc(12'h020, 32'h0, "unmapped data");
    chk("unmapped err", {31'h0, err}, 32'h1);
    end_of_test();
  end
  // Whole run is about 3000 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
